// file: core/srx_debug_regs.sv
/*
  APB register bank for receiver debug and status: per-lane mismatch
  counters, scan-done flags, loss-of-signal threshold and enable,
  equalizer vote size, recovery freeze and gray-coded phase readback.
  Assumes counts and phases come from logic on pclk; scan-done flags
  arrive asynchronously from the scan engine.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srx_params.svh"

module srx_debug_regs
  import srx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SRX_ADDR_W-1:0] paddr,
  input wire logic [`SRX_DATA_W-1:0] pwdata,
  output logic [`SRX_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`SRX_LANES-1:0] scan_complete_in,
  input wire logic [`SRX_LANES*`SRX_COUNT_W-1:0] lane_mismatch_count_in,
  input wire logic [`SRX_LANES*`SRX_PHASE_W-1:0] recovery_phase_in,
  output logic [`SRX_CODE_MSB:0] signal_loss_threshold,
  output logic [`SRX_MV_W-1:0] signal_loss_threshold_mv,
  output logic signal_loss_detect_enable,
  output logic signal_loss_detect_active,
  output logic [`SRX_VOTE_W-1:0] equalizer_vote_count,
  output logic recovery_freeze,
  output logic [`SRX_LANE_W-1:0] phase_lane_select
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] thresh_ff;
  logic [7:0] vote_ff;
  logic [7:0] freeze_ff;
  srx_lane_t lanesel_ff;
  logic losen_ff;
  srx_count_t count_ff [`SRX_LANES];
  logic [`SRX_LANES-1:0] done_q_ff;
  srx_phase_t phase_ff;
  logic [`SRX_DATA_W-1:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [`SRX_MV_W-1:0] mv_ff;
  logic active_ff;
  srx_vote_t votes_ff;

  logic [`SRX_LANES-1:0] done_sync;
  logic [9:0] idx;
  logic setup;
  logic wr_en;
  logic hit_count;
  srx_lane_t count_lane;
  logic mapped;
  logic [`SRX_DATA_W-1:0] nxt_rdata;
  srx_phase_t sel_phase;

  // ----------------------------------------------------------------
  // Scan-done crossing
  // ----------------------------------------------------------------
  srx_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(scan_complete_in),
    .sync_out(done_sync)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign idx = paddr[`SRX_ADDR_W-1:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign hit_count = (idx >= `SRX_IDX_COUNT0) &&
                     (idx < (`SRX_IDX_COUNT0 + 10'(`SRX_LANES)));
  assign count_lane = srx_lane_t'(idx - `SRX_IDX_COUNT0);

  always_comb begin
    mapped = 1'b1;
    nxt_rdata = '0;
    if (hit_count) begin
      nxt_rdata = {16'h0000, count_ff[count_lane]};
    end else begin
      case (idx)
        `SRX_IDX_DONE: nxt_rdata = {16'h0000, done_sync};
        `SRX_IDX_THRESH: nxt_rdata = {24'h000000, thresh_ff};
        `SRX_IDX_VOTE: nxt_rdata = {24'h000000, vote_ff};
        `SRX_IDX_FREEZE: nxt_rdata = {24'h000000, freeze_ff};
        `SRX_IDX_PHASE: nxt_rdata = {24'h000000, phase_ff};
        `SRX_IDX_LANESEL: nxt_rdata = {28'h0000000, lanesel_ff};
        `SRX_IDX_LOSEN: nxt_rdata = {31'h00000000, losen_ff};
        default: mapped = 1'b0;
      endcase
    end
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB answer: read data captured in setup, one access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped;
      if (setup && !pwrite && mapped) begin
        prdata_ff <= nxt_rdata;
      end else if (setup) begin
        prdata_ff <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh_ff <= `SRX_RST_THRESH;
      vote_ff <= `SRX_RST_VOTE;
      freeze_ff <= `SRX_RST_FREEZE;
      lanesel_ff <= `SRX_RST_LANESEL;
      losen_ff <= `SRX_RST_LOSEN;
    end else if (wr_en) begin
      case (idx)
        `SRX_IDX_THRESH: thresh_ff <= pwdata[7:0];
        `SRX_IDX_VOTE: vote_ff <= pwdata[7:0];
        `SRX_IDX_FREEZE: freeze_ff <= pwdata[7:0];
        `SRX_IDX_LANESEL: lanesel_ff <= pwdata[`SRX_LANE_W-1:0];
        `SRX_IDX_LOSEN: losen_ff <= pwdata[`SRX_LOSEN_BIT];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-lane mismatch snapshot, taken as each scan completes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q_ff <= '0;
    end else begin
      done_q_ff <= done_sync;
    end
  end

  for (genvar n = 0; n < `SRX_LANES; n++) begin : g_lane
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        count_ff[n] <= '0;
      end else if (done_sync[n] && !done_q_ff[n]) begin
        count_ff[n] <=
          lane_mismatch_count_in[n*`SRX_COUNT_W +: `SRX_COUNT_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Recovery phase readback, held while frozen
  // ----------------------------------------------------------------
  assign sel_phase =
    recovery_phase_in[lanesel_ff*`SRX_PHASE_W +: `SRX_PHASE_W];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= '0;
    end else if (!freeze_ff[`SRX_FREEZE_BIT]) begin
      phase_ff <= srx_to_gray(sel_phase);
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls toward the receiver lanes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mv_ff <= '0;
      active_ff <= 1'b0;
      votes_ff <= '1;
    end else begin
      if (thresh_ff[`SRX_CODE_MSB:0] >= `SRX_THRESH_MIN) begin
        mv_ff <= 8'(thresh_ff[`SRX_CODE_MSB:0] * `SRX_MV_STEP);
      end else begin
        mv_ff <= '0;
      end
      active_ff <= losen_ff &&
                   (thresh_ff[`SRX_CODE_MSB:0] >= `SRX_THRESH_MIN);
      votes_ff <= srx_vote_decode(vote_ff[`SRX_CODE_MSB:0]);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign signal_loss_threshold = thresh_ff[`SRX_CODE_MSB:0];
  assign signal_loss_threshold_mv = mv_ff;
  assign signal_loss_detect_enable = losen_ff;
  assign signal_loss_detect_active = active_ff;
  assign equalizer_vote_count = votes_ff;
  assign recovery_freeze = freeze_ff[`SRX_FREEZE_BIT];
  assign phase_lane_select = lanesel_ff;

endmodule : srx_debug_regs

`default_nettype wire

// file: core/srx_params.svh
/*
  Constants of the receiver debug and status register bank: register
  indices, field positions, reset values and bus widths.
  Assumes it is included by bare name from the package and modules.
*/
`ifndef SRX_PARAMS_SVH
`define SRX_PARAMS_SVH

`define SRX_LANES 16
`define SRX_LANE_W 4
`define SRX_COUNT_W 16
`define SRX_PHASE_W 8
`define SRX_ADDR_W 12
`define SRX_DATA_W 32
`define SRX_VOTE_W 9
`define SRX_MV_W 8

// Register indices; byte address is four times the index
`define SRX_IDX_DONE 10'h1f6
`define SRX_IDX_COUNT0 10'h210
`define SRX_IDX_THRESH 10'h234
`define SRX_IDX_VOTE 10'h235
`define SRX_IDX_FREEZE 10'h238
`define SRX_IDX_PHASE 10'h239
`define SRX_IDX_LANESEL 10'h23a
`define SRX_IDX_LOSEN 10'h23b

// Reset values
`define SRX_RST_THRESH 8'h08
`define SRX_RST_VOTE 8'h00
`define SRX_RST_FREEZE 8'h00
`define SRX_RST_LANESEL 4'h0
`define SRX_RST_LOSEN 1'b0

// Field positions
`define SRX_CODE_MSB 3
`define SRX_FREEZE_BIT 0
`define SRX_LOSEN_BIT 0

// Threshold step in mV and lowest usable code
`define SRX_MV_STEP 8'h0f
`define SRX_THRESH_MIN 4'h2

`endif

// file: core/srx_pkg.sv
/*
  Types and decode helpers of the receiver debug register bank.
  Assumes srx_params.svh is on the include path.
*/
`include "srx_params.svh"

package srx_pkg;

  typedef logic [`SRX_LANE_W-1:0] srx_lane_t;
  typedef logic [`SRX_COUNT_W-1:0] srx_count_t;
  typedef logic [`SRX_PHASE_W-1:0] srx_phase_t;
  typedef logic [`SRX_VOTE_W-1:0] srx_vote_t;

  // Votes needed before a gain step; reserved codes fall back to default
  function automatic srx_vote_t srx_vote_decode(input logic [3:0] code);
    srx_vote_t v;
    case (code)
      4'h2: v = 9'h001;
      4'h3: v = 9'h003;
      4'h4: v = 9'h007;
      4'h5: v = 9'h00f;
      4'h6: v = 9'h01f;
      4'h7: v = 9'h03f;
      4'h8: v = 9'h07f;
      4'h9: v = 9'h0ff;
      default: v = 9'h1ff;
    endcase
    return v;
  endfunction : srx_vote_decode

  function automatic srx_phase_t srx_to_gray(input srx_phase_t b);
    return b ^ (b >> 1);
  endfunction : srx_to_gray

endpackage : srx_pkg

// file: core/srx_sync.sv
/*
  Three-stage synchroniser with agreement filter for the scan-done flags.
  Assumes the flags are levels from outside the pclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srx_params.svh"

module srx_sync
  import srx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`SRX_LANES-1:0] async_in,
  output logic [`SRX_LANES-1:0] sync_out
);

  logic [`SRX_LANES-1:0] s1_ff;
  logic [`SRX_LANES-1:0] s2_ff;
  logic [`SRX_LANES-1:0] s3_ff;
  logic [`SRX_LANES-1:0] out_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit changes only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ff <= '0;
    end else begin
      out_ff <= (s2_ff & s3_ff) | (out_ff & (s2_ff | s3_ff));
    end
  end

  assign sync_out = out_ff;

endmodule : srx_sync

`default_nettype wire

// file: test/srx_debug_regs_sva.sv
/*
  Port checker for the receiver debug register bank.
  Assumes it is bound to srx_debug_regs by the testbench top file.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srx_params.svh"

module srx_debug_regs_sva
  import srx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SRX_ADDR_W-1:0] paddr,
  input wire logic [`SRX_DATA_W-1:0] pwdata,
  input wire logic [`SRX_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [`SRX_CODE_MSB:0] signal_loss_threshold,
  input wire logic [`SRX_MV_W-1:0] signal_loss_threshold_mv,
  input wire logic signal_loss_detect_enable,
  input wire logic signal_loss_detect_active,
  input wire logic [`SRX_VOTE_W-1:0] equalizer_vote_count,
  input wire logic recovery_freeze
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY_ONE: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_ALIGN: assert property (psel && !penable && paddr[1:0] != 2'h0
    |=> pslverr && pready) else $error("misaligned access not refused");
  AST_MV: assert property (signal_loss_threshold >= 4'h2 |=>
    signal_loss_threshold_mv == 8'(15 * $past(signal_loss_threshold)))
    else $error("threshold level wrong");
  AST_MV_RSVD: assert property (signal_loss_threshold < 4'h2 |=>
    signal_loss_threshold_mv == 8'h00 && !signal_loss_detect_active)
    else $error("reserved threshold code not suppressed");
  AST_ACTIVE: assert property (signal_loss_detect_enable &&
    signal_loss_threshold >= 4'h2 |=> signal_loss_detect_active)
    else $error("loss detector not active");
  AST_VOTE_LEGAL: assert property (equalizer_vote_count != 9'h000 &&
    $onehot({1'b0, equalizer_vote_count} + 10'h001))
    else $error("vote count not a legal size");
  AST_VOTE_WR: assert property (psel && penable && pready && pwrite &&
    paddr == 12'h8d4 && pwdata[3:0] == 4'h2 |=> ##1
    equalizer_vote_count == 9'h001) else $error("vote code 2 not one vote");
  AST_FREEZE_WR: assert property (
    psel && penable && pready && pwrite && paddr == 12'h8e0
    |=> recovery_freeze == $past(pwdata[0]))
    else $error("freeze bit not written");
  AST_THRESH_RD: assert property (psel && !penable && !pwrite &&
    paddr == 12'h8d0 |=> prdata[3:0] == signal_loss_threshold)
    else $error("threshold readback wrong");
endmodule : srx_debug_regs_sva
`default_nettype wire

// file: test/srx_debug_regs_tb_top.sv
/*
  Self-checking testbench of the receiver debug register bank over APB.
  Assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srx_params.svh"

module srx_debug_regs_tb_top;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] scan_complete_in;
  logic [255:0] lane_mismatch_count_in;
  logic [127:0] recovery_phase_in;
  logic [3:0] signal_loss_threshold, phase_lane_select;
  logic [7:0] signal_loss_threshold_mv;
  logic signal_loss_detect_enable, signal_loss_detect_active, recovery_freeze;
  logic [8:0] equalizer_vote_count;
  int miscompares = 0;
  int checks_done = 0;
  int i;

  always #20 pclk = ~pclk;

  srx_debug_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .scan_complete_in,
    .lane_mismatch_count_in, .recovery_phase_in, .signal_loss_threshold,
    .signal_loss_threshold_mv, .signal_loss_detect_enable,
    .signal_loss_detect_active, .equalizer_vote_count, .recovery_freeze,
    .phase_lane_select);

  // --------------------------------
  // Helpers
  // --------------------------------
  function automatic logic [7:0] ph(input int n);
    return 8'(n * 17 + 3);
  endfunction : ph

  function automatic logic [31:0] gr(input logic [7:0] b);
    return {24'h0, b ^ (b >> 1)};
  endfunction : gr

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] ex, got);
    checks_done++;
    if (got !== ex) begin
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      miscompares++;
    end
  endtask : chk

  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      end_of_test;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : acc

  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] ex);
    acc(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask : rdc

  // --------------------------------
  // Sequence
  // --------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, scan_complete_in} <= '0;
    for (i = 0; i < 16; i++) begin
      lane_mismatch_count_in[16*i +: 16] <= 16'(16'h1000 + i * 16'h0111);
      recovery_phase_in[8*i +: 8] <= ph(i);
    end
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("thresh", 12'h8d0, 32'h08);
    rdc("vote", 12'h8d4, 32'h0);
    rdc("freeze", 12'h8e0, 32'h0);
    rdc("done", 12'h7d8, 32'h0);
    acc(1'b1, 12'h8ec, 32'h1);
    chk("enable", 32'h1, 32'(signal_loss_detect_enable));
    rdc("enable rd", 12'h8ec, 32'h1);
    for (i = 0; i < 16; i++) begin
      acc(1'b1, 12'h8d0, 32'(i));
      chk("mv", (i < 2) ? 32'h0 : 32'(15 * i),
        32'(signal_loss_threshold_mv));
      chk("active", 32'(i >= 2), 32'(signal_loss_detect_active));
    end
    for (i = 0; i < 16; i++) begin
      acc(1'b1, 12'h8d4, 32'(i));
      chk("votes", (i >= 2 && i <= 9) ? 32'((1 << (i - 1)) - 1) : 32'd511,
        32'(equalizer_vote_count));
    end
    acc(1'b1, 12'h8d4, 32'h0);
    scan_complete_in <= 16'hffff;
    rd = 32'h0;
    for (i = 0; i < 20 && rd[15:0] !== 16'hffff; i++) begin
      acc(1'b0, 12'h7d8, 32'h0);
    end
    chk("done", 32'h0000ffff, rd);
    for (i = 0; i < 16; i++) begin
      rdc("count", 12'(12'h840 + 4 * i),
        32'(16'h1000 + i * 16'h0111));
    end
    acc(1'b1, 12'h840, 32'hdead);
    rdc("count ro", 12'h840, 32'h1000);
    for (i = 0; i < 16; i++) begin
      acc(1'b1, 12'h8e8, 32'(i));
      chk("lane sel pin", 32'(i), 32'(phase_lane_select));
      rdc("lane sel", 12'h8e8, 32'(i));
      rdc("phase", 12'h8e4, gr(ph(i)));
    end
    acc(1'b1, 12'h8e0, 32'h1);
    chk("freeze pin", 32'h1, 32'(recovery_freeze));
    recovery_phase_in <= ~recovery_phase_in;
    rdc("frozen", 12'h8e4, gr(ph(15)));
    acc(1'b1, 12'h8e0, 32'h0);
    chk("thaw pin", 32'h0, 32'(recovery_freeze));
    rdc("tracking", 12'h8e4, gr(~ph(15)));
    acc(1'b0, 12'h004, 32'h0);
    chk("unmapped", 32'h1, 32'(er));
    acc(1'b1, 12'h8d1, 32'h3);
    chk("misaligned", 32'h1, 32'(er));
    rdc("thresh kept", 12'h8d0, 32'h0f);
    end_of_test;
  end
endmodule : srx_debug_regs_tb_top

bind srx_debug_regs srx_debug_regs_sva u_sva (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .signal_loss_threshold, .signal_loss_threshold_mv,
  .signal_loss_detect_enable, .signal_loss_detect_active,
  .equalizer_vote_count, .recovery_freeze);
`default_nettype wire
